// [hw/fpl_pkg.sv]
// Shared constants and types of the fp load and lazy restore unit
package fpl_pkg;
   // Register bus map
   localparam int FPL_AW = 8;
   localparam logic [7:0] FPL_CTRL_OFS = 8'h00; // Control bits
   localparam logic [7:0] FPL_STAT_OFS = 8'h04; // Sticky status, busy
   localparam logic [1:0] FPL_AXI_OKAY = 2'h0;
   localparam logic [1:0] FPL_AXI_SLVERR = 2'h2;
   // Instruction encodings
   localparam logic [7:0] FPL_LD_OP = 8'hed; // Load, bits 31:24
   localparam logic [1:0] FPL_LD_LS = 2'h1; // Load, bits 21:20
   localparam logic [2:0] FPL_LD_CP = 3'h5; // Load, bits 11:9
   localparam logic [11:0] FPL_LL_OP = 12'hec3; // Restore, bits 31:20
   localparam logic [15:0] FPL_LL_LO = 16'h0a00; // Restore, bits 15:0
   localparam int FPL_U_BIT = 23; // Offset direction
   localparam int FPL_D_BIT = 22; // Extra destination bit
   localparam int FPL_BASE_LSB = 16; // Base register field
   localparam int FPL_VD_LSB = 12; // Destination field
   localparam int FPL_SZ_BIT = 8; // Double precision
   localparam logic [3:0] FPL_PC_REG = 4'hf; // Field value naming the PC
   // Address arithmetic
   localparam logic [31:0] FPL_PC_MASK = 32'hffff_fffc;
   localparam logic [31:0] FPL_WORD_BYTES = 32'h0000_0004;
   localparam logic [31:0] FPL_STATW_OFS = 32'h0000_0040;
   localparam logic [31:0] FPL_UPPER_OFS = 32'h0000_0048;
   localparam logic [5:0] FPL_STATW_IDX = 6'h10; // Step reading status
   localparam logic [5:0] FPL_UPPER_IDX = 6'h11; // First upper-bank step
   localparam logic [5:0] FPL_LAST_SEC = 6'h20; // Last step, upper bank
   // Execution states
   typedef enum logic [1:0] {
      FPL_IDLE = 2'b00,
      FPL_LOAD = 2'b01,
      FPL_RESTORE = 2'b10
   } fpl_state_t;
   // Completion codes
   typedef enum logic [2:0] {
      FPL_RES_OK = 3'b000,
      FPL_RES_NOP = 3'b001,
      FPL_RES_UNDEF = 3'b010,
      FPL_RES_USAGE = 3'b011,
      FPL_RES_BUS = 3'b100,
      FPL_RES_MMAN = 3'b101,
      FPL_RES_SECF = 3'b110
   } fpl_res_t;
   // Memory answer codes
   typedef enum logic [1:0] {
      FPL_RSP_OK = 2'b00,
      FPL_RSP_BUS = 2'b01,
      FPL_RSP_MMAN = 2'b10,
      FPL_RSP_SECF = 2'b11
   } fpl_rsp_t;
   typedef struct packed {
      logic cp_enable;
      logic lazy_save_pending;
      logic treat_fp_as_secure;
      logic secure_fp_in_use;
      logic secure_state;
      logic main_ext;
      logic fp_present;
      logic big_endian;
   } fpl_ctrl_t;
   typedef struct packed {
      logic misalign_flag;
      logic fp_context_active;
   } fpl_status_t;
   typedef struct packed {
      logic valid;
      logic [31:0] word;
      logic [31:0] pc;
      logic [31:0] base;
   } fpl_instr_t;
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } fpl_mem_req_t;
   typedef struct packed {
      logic ack;
      fpl_rsp_t resp;
      logic [31:0] data;
   } fpl_mem_rsp_t;
   typedef struct packed {
      logic we;
      logic status_word;
      logic dword;
      logic [4:0] idx;
      logic [63:0] data;
   } fpl_fpr_wr_t;
   typedef struct packed {
      logic valid;
      fpl_res_t res;
   } fpl_done_t;
   localparam fpl_ctrl_t FPL_CTRL_RST = 8'h06; // FP and main ext present
   localparam fpl_status_t FPL_STAT_RST = 2'h0;
endpackage : fpl_pkg

// [hw/fpl_core.sv]
// Decode and execute unit for fp single and double loads and lazy restores
`timescale 1ns/1ps
`default_nettype none
module fpl_core (
   input wire logic ref_clk,
   input wire logic rst,
   input wire fpl_pkg::fpl_instr_t instr_in, // Issued instruction
   output var logic instr_ready, // Idle, can take one
   output var fpl_pkg::fpl_mem_req_t mem_req, // Word read request
   input wire fpl_pkg::fpl_mem_rsp_t mem_rsp, // Read answer
   output var fpl_pkg::fpl_fpr_wr_t fpr_wr, // Register file write
   output var fpl_pkg::fpl_done_t done, // Completion pulse
   input wire logic s_axi_awvalid,
   output var logic s_axi_awready,
   input wire logic [fpl_pkg::FPL_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output var logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output var logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output var logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output var logic s_axi_arready,
   input wire logic [fpl_pkg::FPL_AW-1:0] s_axi_araddr,
   output var logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output var logic [31:0] s_axi_rdata,
   output var logic [1:0] s_axi_rresp
);
   import fpl_pkg::*;

   // Bus slave state
   logic aw_hold_reg, aw_hold_next; // Write address captured
   logic w_hold_reg, w_hold_next; // Write data captured
   logic [FPL_AW-1:0] awaddr_reg, awaddr_next;
   logic [7:0] wdata_reg, wdata_next; // Only byte 0 holds bits
   logic wstrb_reg, wstrb_next; // Lane 0 strobe
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic wr_ctrl; // Control write this cycle
   logic wr_stat; // Status clear this cycle
   // Execution state
   fpl_state_t state_reg, state_next;
   logic [5:0] idx_reg, idx_next; // Word step
   logic [5:0] last_reg, last_next; // Final restore step
   logic [31:0] w1_reg, w1_next; // First word of a double
   logic [31:0] base_reg, base_next; // Restore frame base
   logic dw_reg, dw_next; // Double-precision load
   logic [4:0] dst_reg, dst_next; // Destination register
   logic ready_reg, ready_next;
   fpl_mem_req_t mem_reg, mem_next;
   fpl_fpr_wr_t wr_reg, wr_next;
   fpl_done_t done_reg, done_next;
   fpl_ctrl_t ctrl_reg, ctrl_next;
   fpl_status_t stat_reg, stat_next;
   // Decode terms
   logic take, is_ld, is_ll, ll_go;
   logic [3:0] base_field;
   logic [31:0] byte_offset, base_sel, ea;

   // Register select, shared by read and write paths
   function automatic logic [1:0] fpl_sel(input logic [FPL_AW-1:0] a);
      fpl_sel = (a == FPL_CTRL_OFS) ? 2'h1 :
                (a == FPL_STAT_OFS) ? 2'h2 : 2'h0;
   endfunction : fpl_sel

   // Memory answer to completion code
   function automatic fpl_res_t fpl_fault(input fpl_rsp_t r);
      unique case (r)
         FPL_RSP_BUS: fpl_fault = FPL_RES_BUS;
         FPL_RSP_MMAN: fpl_fault = FPL_RES_MMAN;
         FPL_RSP_SECF: fpl_fault = FPL_RES_SECF;
         FPL_RSP_OK: fpl_fault = FPL_RES_OK;
      endcase
   endfunction : fpl_fault

   // One-cycle completion record
   function automatic fpl_done_t fpl_fin(input fpl_res_t r);
      fpl_fin = '{valid: 1'b1, res: r};
   endfunction : fpl_fin

   // Restore frame address of a step
   function automatic logic [31:0] fpl_ll_addr(input logic [31:0] b,
                                               input logic [5:0] i);
      logic [5:0] j;
      j = i - FPL_UPPER_IDX;
      if (i < FPL_STATW_IDX) begin
         fpl_ll_addr = b + {24'h0, i, 2'b00};
      end else if (i == FPL_STATW_IDX) begin
         fpl_ll_addr = b + FPL_STATW_OFS;
      end else begin
         fpl_ll_addr = b + FPL_UPPER_OFS + {24'h0, j, 2'b00};
      end
   endfunction : fpl_ll_addr

   // Field extraction and address forming
   assign take = instr_in.valid && ready_reg;
   assign base_field = instr_in.word[FPL_BASE_LSB +: 4];
   assign is_ld = instr_in.word[31:24] == FPL_LD_OP &&
                  instr_in.word[21:20] == FPL_LD_LS &&
                  instr_in.word[11:9] == FPL_LD_CP;
   assign is_ll = instr_in.word[31:20] == FPL_LL_OP &&
                  instr_in.word[15:0] == FPL_LL_LO;
   // Offset is imm8 times four, so 0..1020 in steps of 4
   assign byte_offset = {22'h0, instr_in.word[7:0], 2'b00};
   assign base_sel = (base_field == FPL_PC_REG) ?
                     (instr_in.pc & FPL_PC_MASK) : instr_in.base;
   // Add flag true adds; a negative literal arrives as magnitude, U=0
   assign ea = instr_in.word[FPL_U_BIT] ? base_sel + byte_offset :
               base_sel - byte_offset;
   // Restore that reaches its data path
   assign ll_go = is_ll && ctrl_reg.main_ext && ctrl_reg.secure_state &&
                  base_field != FPL_PC_REG && ctrl_reg.fp_present &&
                  ctrl_reg.secure_fp_in_use && ctrl_reg.cp_enable;

   // Bus slave: address and data taken in either order
   always_comb begin
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      if (s_axi_awvalid && awready_reg) begin // Address taken
         aw_hold_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin // Data taken
         w_hold_next = 1'b1;
         wdata_next = s_axi_wdata[7:0];
         wstrb_next = s_axi_wstrb[0];
      end
      if (bvalid_reg && s_axi_bready) begin // Response accepted
         bvalid_next = 1'b0;
      end
      if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin // Commit
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (fpl_sel(awaddr_reg) == 2'h0) ?
                      FPL_AXI_SLVERR : FPL_AXI_OKAY;
         wr_ctrl = fpl_sel(awaddr_reg) == 2'h1 && wstrb_reg;
         wr_stat = fpl_sel(awaddr_reg) == 2'h2 && wstrb_reg;
      end
      if (rvalid_reg && s_axi_rready) begin // Read data accepted
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && arready_reg) begin // Read taken
         rvalid_next = 1'b1;
         rresp_next = FPL_AXI_OKAY;
         unique case (fpl_sel(s_axi_araddr))
            2'h1: rdata_next = {24'h0, ctrl_reg};
            2'h2: rdata_next = {29'h0, state_reg != FPL_IDLE, stat_reg};
            default: begin // Unmapped reads zero with error
               rdata_next = 32'h0;
               rresp_next = FPL_AXI_SLVERR;
            end
         endcase
      end
      // One write and one read in flight at most
      awready_next = !aw_hold_next && !bvalid_next;
      wready_next = !w_hold_next && !bvalid_next;
      arready_next = !rvalid_next;
   end

   // Bus slave registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 8'h0;
         wstrb_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= FPL_AXI_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= FPL_AXI_OKAY;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // Decode and execution sequence
   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      last_next = last_reg;
      w1_next = w1_reg;
      base_next = base_reg;
      dw_next = dw_reg;
      dst_next = dst_reg;
      mem_next = mem_reg;
      wr_next = '0;
      done_next = '0;
      ctrl_next = ctrl_reg;
      // Clear-on-one first, so a hardware set below wins
      stat_next = wr_stat ? (stat_reg & ~fpl_status_t'(wdata_reg[1:0])) :
                  stat_reg;
      unique case (state_reg)
         FPL_IDLE: begin
            if (take && is_ld) begin
               dw_next = instr_in.word[FPL_SZ_BIT];
               dst_next = instr_in.word[FPL_SZ_BIT] ?
                  {instr_in.word[FPL_D_BIT], instr_in.word[FPL_VD_LSB +: 4]} :
                  {instr_in.word[FPL_VD_LSB +: 4], instr_in.word[FPL_D_BIT]};
               idx_next = 6'h0;
               if (!ctrl_reg.fp_present) begin
                  done_next = fpl_fin(FPL_RES_UNDEF);
               end else if (!ctrl_reg.cp_enable) begin
                  done_next = fpl_fin(FPL_RES_USAGE);
               end else if (ea[1:0] != 2'h0) begin
                  stat_next.misalign_flag = 1'b1;
                  done_next = fpl_fin(FPL_RES_USAGE);
               end else begin
                  state_next = FPL_LOAD;
                  mem_next = '{valid: 1'b1, addr: ea};
               end
            end else if (take && is_ll) begin
               base_next = instr_in.base;
               idx_next = 6'h0;
               last_next = ctrl_reg.treat_fp_as_secure ?
                           FPL_LAST_SEC : FPL_STATW_IDX;
               if (!ctrl_reg.main_ext || !ctrl_reg.secure_state) begin
                  done_next = fpl_fin(FPL_RES_UNDEF);
               end else if (base_field == FPL_PC_REG) begin
                  done_next = fpl_fin(FPL_RES_UNDEF);
               end else if (!ctrl_reg.fp_present ||
                            !ctrl_reg.secure_fp_in_use) begin
                  done_next = fpl_fin(FPL_RES_NOP);
               end else if (!ctrl_reg.cp_enable) begin
                  done_next = fpl_fin(FPL_RES_USAGE);
               end else if (ctrl_reg.lazy_save_pending) begin
                  // Registers still hold the live state; no memory read
                  ctrl_next.lazy_save_pending = 1'b0;
                  stat_next.fp_context_active = 1'b1;
                  done_next = fpl_fin(FPL_RES_OK);
               end else if (instr_in.base[2:0] != 3'h0) begin
                  stat_next.misalign_flag = 1'b1;
                  done_next = fpl_fin(FPL_RES_USAGE);
               end else begin
                  state_next = FPL_RESTORE;
                  mem_next = '{valid: 1'b1,
                               addr: fpl_ll_addr(instr_in.base, 6'h0)};
               end
            end else if (take) begin // Not an opcode this unit owns
               done_next = fpl_fin(FPL_RES_UNDEF);
            end
         end
         FPL_LOAD: begin
            if (mem_rsp.ack) begin
               mem_next.valid = 1'b0;
               if (mem_rsp.resp != FPL_RSP_OK) begin
                  state_next = FPL_IDLE;
                  done_next = fpl_fin(fpl_fault(mem_rsp.resp));
               end else if (dw_reg && idx_reg == 6'h0) begin
                  w1_next = mem_rsp.data;
                  idx_next = 6'h1;
                  mem_next = '{valid: 1'b1,
                     addr: mem_reg.addr + FPL_WORD_BYTES};
               end else begin
                  wr_next.we = 1'b1;
                  wr_next.dword = dw_reg;
                  wr_next.idx = dst_reg;
                  if (!dw_reg) begin
                     wr_next.data = {32'h0, mem_rsp.data};
                  end else if (ctrl_reg.big_endian) begin
                     wr_next.data = {w1_reg, mem_rsp.data};
                  end else begin
                     wr_next.data = {mem_rsp.data, w1_reg};
                  end
                  state_next = FPL_IDLE;
                  done_next = fpl_fin(FPL_RES_OK);
               end
            end
         end
         FPL_RESTORE: begin
            if (mem_rsp.ack) begin
               mem_next.valid = 1'b0;
               if (mem_rsp.resp != FPL_RSP_OK) begin
                  state_next = FPL_IDLE;
                  done_next = fpl_fin(fpl_fault(mem_rsp.resp));
               end else begin
                  wr_next.we = 1'b1;
                  wr_next.status_word = idx_reg == FPL_STATW_IDX;
                  wr_next.idx = (idx_reg > FPL_STATW_IDX) ?
                                5'(idx_reg - 6'h1) : idx_reg[4:0];
                  wr_next.data = {32'h0, mem_rsp.data};
                  if (idx_reg == last_reg) begin
                     state_next = FPL_IDLE;
                     stat_next.fp_context_active = 1'b1;
                     done_next = fpl_fin(FPL_RES_OK);
                  end else begin
                     idx_next = idx_reg + 6'h1;
                     mem_next = '{valid: 1'b1,
                        addr: fpl_ll_addr(base_reg, idx_reg + 6'h1)};
                  end
               end
            end
         end
         default: begin // Illegal code returns to idle
            state_next = FPL_IDLE;
            mem_next = '0;
         end
      endcase
      // Software write of control lands after the hardware clear
      if (wr_ctrl) begin
         ctrl_next = fpl_ctrl_t'(wdata_reg);
      end
      ready_next = state_next == FPL_IDLE;
   end

   // Execution registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= FPL_IDLE;
         idx_reg <= 6'h0;
         last_reg <= 6'h0;
         w1_reg <= 32'h0;
         base_reg <= 32'h0;
         dw_reg <= 1'b0;
         dst_reg <= 5'h0;
         ready_reg <= 1'b0;
         mem_reg <= '0;
         wr_reg <= '0;
         done_reg <= '0;
         ctrl_reg <= FPL_CTRL_RST;
         stat_reg <= FPL_STAT_RST;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         last_reg <= last_next;
         w1_reg <= w1_next;
         base_reg <= base_next;
         dw_reg <= dw_next;
         dst_reg <= dst_next;
         ready_reg <= ready_next;
         mem_reg <= mem_next;
         wr_reg <= wr_next;
         done_reg <= done_next;
         ctrl_reg <= ctrl_next;
         stat_reg <= stat_next;
      end
   end

   // Outputs, all from flip-flops
   assign instr_ready = ready_reg;
   assign mem_req = mem_reg;
   assign fpr_wr = wr_reg;
   assign done = done_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Checks on the execution sequence
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_ld_addr_form: assert property (take && is_ld &&
      ctrl_reg.fp_present &&
      ctrl_reg.cp_enable && ea[1:0] == 2'h0 |=> mem_req.valid &&
      mem_req.addr == ($past(instr_in.word[FPL_U_BIT]) ?
      $past(base_sel) + $past(byte_offset) :
      $past(base_sel) - $past(byte_offset)))
      else $error("load address not base plus or minus offset");
   a_pc_base_align: assert property (take && is_ld &&
      base_field == FPL_PC_REG && instr_in.word[FPL_U_BIT] &&
      ctrl_reg.fp_present && ctrl_reg.cp_enable && ea[1:0] == 2'h0 |=>
      mem_req.addr == ($past(instr_in.pc) & FPL_PC_MASK) +
      $past(byte_offset))
      else $error("literal load base not aligned pc");
   a_dword_second: assert property (state_reg == FPL_LOAD &&
      dw_reg && idx_reg == 6'h0 && mem_rsp.ack &&
      mem_rsp.resp == FPL_RSP_OK |=>
      mem_req.valid && mem_req.addr == $past(mem_req.addr) + FPL_WORD_BYTES)
      else $error("second word not at address plus four");
   a_endian_order: assert property (fpr_wr.we && fpr_wr.dword |->
      ($past(ctrl_reg.big_endian) ? fpr_wr.data[63:32] :
      fpr_wr.data[31:0]) == w1_reg)
      else $error("doubleword halves in wrong order");
   a_nonsec_undef: assert property (take && is_ll &&
      ctrl_reg.main_ext && !ctrl_reg.secure_state |=>
      done.valid && done.res == FPL_RES_UNDEF &&
      !mem_req.valid)
      else $error("non-secure restore not undefined");
   a_pend_cancel: assert property (take && ll_go &&
      ctrl_reg.lazy_save_pending && !wr_ctrl |=>
      !ctrl_reg.lazy_save_pending && !mem_req.valid && done.valid &&
      done.res == FPL_RES_OK)
      else $error("pending save not cancelled without reads");
   a_misalign_flag: assert property (take && ll_go &&
      !ctrl_reg.lazy_save_pending && instr_in.base[2:0] != 3'h0 |=>
      stat_reg.misalign_flag && done.valid && done.res == FPL_RES_USAGE)
      else $error("misaligned restore base not faulted");
   a_statw_addr: assert property (state_reg == FPL_RESTORE &&
      idx_reg == FPL_STATW_IDX && mem_req.valid |->
      mem_req.addr == base_reg + FPL_STATW_OFS)
      else $error("status word read from wrong address");
   a_ctx_active: assert property (done.valid &&
      done.res == FPL_RES_OK &&
      $past(state_reg) == FPL_RESTORE |-> stat_reg.fp_context_active)
      else $error("restore did not mark context active");
endmodule : fpl_core
`default_nettype wire

// [verif/fpl_mem_model.sv]
// Memory partner that answers the unit's word reads
`timescale 1ns/1ps
`default_nettype none
module fpl_mem_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire fpl_pkg::fpl_mem_req_t mem_req,
   input wire logic slow, // Insert a wait cycle before each instruction's first read
   input wire fpl_pkg::fpl_rsp_t fault, // Answer code to give
   output var fpl_pkg::fpl_mem_rsp_t mem_rsp,
   output var logic [15:0] reads // Words handed out
);
   import fpl_pkg::*;
   logic wt;
   // Idle data flips so that a stale word never looks valid
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mem_rsp <= '0;
         wt <= 1'b0;
         reads <= 16'h0;
      end else if (mem_req.valid && !mem_rsp.ack && (wt || !slow)) begin
         mem_rsp <= {1'b1, fault,
                     mem_req.addr ^ 32'h3c96_a5f0};
         reads <= reads + 16'h1;
         wt <= 1'b0;
      end else begin
         mem_rsp <= {1'b0, fault, ~mem_rsp.data};
         wt <= mem_req.valid;
      end
   end
endmodule : fpl_mem_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench of the fp load and lazy restore unit
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
$display("mismatch %0t %h %h", $time, a, b); end end
module tb;
   import fpl_pkg::*;
   logic ref_clk = 0, rst = 1, slow = 0, instr_ready, s_axi_bvalid, u, sz;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_rvalid;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_arready;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, im;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, pc, bs, ea, r;
   logic [3:0] s_axi_wstrb = 4'hf, bfld;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] reads;
   logic [63:0] q;
   logic [7:0] k; // Last register write: we, status, double, index
   int failures = 0, check_count = 0, cyc = 0, seed = 32'h1ef29112;
   fpl_instr_t instr_in = '0;
   fpl_rsp_t fault = FPL_RSP_OK;
   fpl_mem_req_t mem_req;
   fpl_mem_rsp_t mem_rsp;
   fpl_fpr_wr_t fpr_wr;
   fpl_done_t done;
   fpl_core i_fpl_core (.ref_clk, .rst, .instr_in, .instr_ready, .mem_req,
      .mem_rsp, .fpr_wr, .done, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
   fpl_mem_model i_fpl_mem_model (.ref_clk, .rst, .mem_req, .slow, .fault,
      .mem_rsp, .reads);
   always #2.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] md(input logic [31:0] a);
      return a ^ 32'h3c96_a5f0; // Word the partner returns
   endfunction : md
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge ref_clk); while (!s_axi_bvalid);
      `chk(s_axi_bresp, FPL_AXI_OKAY)
      s_axi_bready <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, logic [1:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `chk({s_axi_rresp, s_axi_rdata}, {e, d})
      @(posedge ref_clk);
   endtask : rd
   // Issue one instruction, hold it until taken, then await completion
   task automatic ex(input logic [31:0] w, p, b, fpl_res_t e, logic [15:0] n);
      logic [15:0] r0;
      r0 = reads;
      instr_in <= {1'b1, w, p, b};
      do @(posedge ref_clk); while (!instr_ready);
      instr_in.valid <= 1'b0;
      do @(posedge ref_clk); while (!done.valid);
      q = fpr_wr.data;
      k = {fpr_wr.we, fpr_wr.status_word, fpr_wr.dword, fpr_wr.idx};
      `chk({done.res, reads - r0}, {e, n})
      @(posedge ref_clk);
   endtask : ex
   task automatic rs(input logic [7:0] c, logic [3:0] f, logic [31:0] b,
      fpl_res_t e, logic [15:0] n);
      wr(FPL_CTRL_OFS, {24'h0, c});
      ex({FPL_LL_OP, f, FPL_LL_LO}, 32'h0, b, e, n);
   endtask : rs
   task automatic results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(FPL_CTRL_OFS, 32'h6, FPL_AXI_OKAY);
      rd(8'h08, 32'h0, FPL_AXI_SLVERR);
      for (int i = 0; i < 24; i++) begin
         pc = $random(seed);
         bs = $random(seed) & FPL_PC_MASK;
         r = $random(seed);
         {u, sz, bfld, im} = {r[14:13], r[11:0]};
         slow <= r[12];
         // Literal loads at the +-1020 extremes, then a zero offset
         if (i < 4) {u, bfld, im} = {i[1], FPL_PC_REG, 8'hff};
         if (i == 4) im = 8'h00;
         wr(FPL_CTRL_OFS, {24'h0, 7'h43, i[0]});
         ea = (bfld == FPL_PC_REG) ? pc & FPL_PC_MASK : bs;
         ea = u ? ea + {22'h0, im, 2'h0} :
              ea - {22'h0, im, 2'h0};
         ex({FPL_LD_OP, u, 1'b0, FPL_LD_LS, bfld, 4'h3, FPL_LD_CP, sz, im},
            pc, bs, FPL_RES_OK, {15'h0, sz} + 16'h1);
         if (sz)
            `chk(q, i[0] ? {md(ea), md(ea + 4)} : {md(ea + 4), md(ea)})
         else
            `chk(q[31:0], md(ea))
         `chk(k, {2'b10, sz, sz ? 5'h03 : 5'h06})
      end
      // Misaligned base: no read, sticky flag, then cleared by a one
      ex(32'hed91_0a00, 32'h0, 32'h102, FPL_RES_USAGE, 16'h0);
      rd(FPL_STAT_OFS, 32'h2, FPL_AXI_OKAY);
      wr(FPL_STAT_OFS, 32'h2);
      rd(FPL_STAT_OFS, 32'h0, FPL_AXI_OKAY);
      // Each memory answer code maps to its own fault
      for (int f = 1; f < 4; f++) begin
         fault <= fpl_rsp_t'(f);
         ex(32'hed91_0a00, 32'h0, 32'h100, fpl_res_t'(f + 3),
            16'h1);
      end
      fault <= FPL_RSP_OK;
      ex(32'h0, 32'h0, 32'h0, FPL_RES_UNDEF, 16'h0); // Foreign opcode
      $display("load tests done");
      rs(8'hde, 4'h3, 32'h2000, FPL_RES_OK, 16'h0);
      rd(FPL_CTRL_OFS, 32'h9e, FPL_AXI_OKAY);
      rd(FPL_STAT_OFS, 32'h1, FPL_AXI_OKAY);
      rs(8'h96, 4'h3, 32'h2000, FPL_RES_UNDEF, 16'h0);
      rs(8'h8e, 4'h3, 32'h2000, FPL_RES_NOP, 16'h0);
      rs(8'h9e, 4'hf, 32'h2000, FPL_RES_UNDEF, 16'h0);
      rs(8'h9a, 4'h3, 32'h2000, FPL_RES_UNDEF, 16'h0);
      rs(8'h9c, 4'h3, 32'h2000, FPL_RES_NOP, 16'h0);
      rs(8'h1e, 4'h3, 32'h2000, FPL_RES_USAGE, 16'h0); // Coprocessor off
      rs(8'h9e, 4'h3, 32'h2004, FPL_RES_USAGE, 16'h0);
      rd(FPL_STAT_OFS, 32'h3, FPL_AXI_OKAY);
      rs(8'hbe, 4'h3, 32'h2000, FPL_RES_OK, 16'h21);
      `chk(q[31:0], md(32'h2084))
      `chk(k, 8'h9f)
      $display("restore tests done");
      results();
   end
endmodule : tb
`default_nettype wire
